// file: logic/nvc_pkg.sv
/*
  nvc_pkg: register map, control field layout, timing constants and
  carrier types for the data store and code read controller.
  assumes a 200 MHz aclk and an AXI4-Lite slave with one word per register.
*/
package nvc_pkg;

  // ****************************************
  // register byte addresses (index times four)
  // ****************************************
  localparam logic [11:0] IDX_DATA_LOW = 12'h10C;
  localparam logic [11:0] IDX_ADDR_LOW = 12'h10D;
  localparam logic [11:0] IDX_ADDR_HIGH = 12'h10F;
  localparam logic [11:0] IDX_CONTROL = 12'h11B;
  localparam logic [11:0] IDX_UNLOCK = 12'h11C;
  localparam logic [11:0] IDX_DATA_HIGH = 12'h18E;
  localparam logic [11:0] IDX_STATUS = 12'h11D;
  localparam logic [13:0] ADDR_DATA_LOW = {IDX_DATA_LOW, 2'b00};
  localparam logic [13:0] ADDR_ADDR_LOW = {IDX_ADDR_LOW, 2'b00};
  localparam logic [13:0] ADDR_ADDR_HIGH = {IDX_ADDR_HIGH, 2'b00};
  localparam logic [13:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
  localparam logic [13:0] ADDR_UNLOCK = {IDX_UNLOCK, 2'b00};
  localparam logic [13:0] ADDR_DATA_HIGH = {IDX_DATA_HIGH, 2'b00};
  localparam logic [13:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

  // ****************************************
  // control fields
  // ****************************************
  localparam int BIT_SPACE = 7;
  localparam int BIT_TIME_HI = 5;
  localparam int BIT_TIME_LO = 4;
  localparam int BIT_FAULT = 3;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_STORE = 1;
  localparam int BIT_READ = 0;
  localparam int BIT_DONE = 0;
  localparam int BIT_BUSY = 1;
  localparam int BIT_LOCKOUT = 2;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam logic [4:0] ADDR_HIGH_MASK = 5'h1F;
  localparam logic [6:0] DATA_ADDR_MASK = 7'h7F;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 200;
  localparam int LIMIT_1_US = 1250;
  localparam int LIMIT_2_US = 2500;
  localparam int LIMIT_3_US = 5000;
  localparam int LIMIT_4_US = 10000;
  localparam int POWERUP_US = 16000;
  localparam int MIN_WRITE_US = 100;
  localparam int LIMIT_1_CYC = LIMIT_1_US * CLK_MHZ;
  localparam int LIMIT_2_CYC = LIMIT_2_US * CLK_MHZ;
  localparam int LIMIT_3_CYC = LIMIT_3_US * CLK_MHZ;
  localparam int LIMIT_4_CYC = LIMIT_4_US * CLK_MHZ;
  localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
  localparam int MIN_WRITE_CYC = MIN_WRITE_US * CLK_MHZ;

  // ****************************************
  // carriers
  // ****************************************
  typedef enum logic [1:0] {
    NVC_AXI_OKAY = 2'b00,
    NVC_AXI_SLVERR = 2'b10
  } nvc_resp_type;

  typedef struct packed {
    logic space_select;
    logic [1:0] time_limit;
    logic write_fault;
    logic write_permit;
    logic store_trigger;
    logic read_trigger;
  } nvc_control_type;

  typedef struct packed {
    logic req;
    logic space;
    logic [12:0] addr;
  } nvc_read_req_type;

  typedef struct packed {
    logic req;
    logic [6:0] addr;
    logic [7:0] data;
  } nvc_write_req_type;

endpackage

// file: logic/nvc_write_timer.sv
/*
  nvc_write_timer: times one store cycle of the data array.
  assumes start is a one-cycle pulse and the array reports verify_ok.
*/
module nvc_write_timer #(
  parameter int LIMIT_1 = nvc_pkg::LIMIT_1_CYC,
  parameter int LIMIT_2 = nvc_pkg::LIMIT_2_CYC,
  parameter int LIMIT_3 = nvc_pkg::LIMIT_3_CYC,
  parameter int LIMIT_4 = nvc_pkg::LIMIT_4_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic start,
  input wire logic [1:0] time_sel,
  input wire logic verify_ok,
  // result
  output logic busy,
  output logic done
);

  logic [31:0] count;
  logic [31:0] limit;
  logic [1:0] sel;
  wire expired = (count + 32'h1 >= limit);

  always_comb begin
    case (sel)
      2'b00: limit = 32'(LIMIT_1);
      2'b01: limit = 32'(LIMIT_2);
      2'b10: limit = 32'(LIMIT_3);
      default: limit = 32'(LIMIT_4);
    endcase
  end

  // the limit is frozen at start so a later field change cannot stretch it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      count <= 32'h0;
      sel <= 2'b00;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        count <= 32'h0;
        sel <= time_sel;
      end else if (busy) begin
        count <= count + 32'h1;
        if (verify_ok || expired) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule

// file: logic/nvc_top.sv
/*
  nvc_top: indirect access controller for a 128-byte data store and
  read-only 8K-word code memory, reached over AXI4-Lite.
  assumes single-cycle synchronous arrays outside, an external write fault
  cause (low-voltage or watchdog reset) flagged on fault_reset_cause.
*/
module nvc_top #(
  parameter int POWERUP_CYCLES = nvc_pkg::POWERUP_CYC,
  parameter int LIMIT_1 = nvc_pkg::LIMIT_1_CYC,
  parameter int LIMIT_2 = nvc_pkg::LIMIT_2_CYC,
  parameter int LIMIT_3 = nvc_pkg::LIMIT_3_CYC,
  parameter int LIMIT_4 = nvc_pkg::LIMIT_4_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fault_reset_cause,
  // axi4-lite write
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // memory arrays
  output nvc_pkg::nvc_read_req_type mem_read,
  input wire logic [15:0] mem_rdata,
  output nvc_pkg::nvc_write_req_type mem_write,
  input wire logic mem_verify_ok,
  // core
  output logic core_stall,
  output logic write_done_flag
);

  // ****************************************
  // state
  // ****************************************
  typedef enum {UNLOCK_IDLE, UNLOCK_FIRST, UNLOCK_ARMED} nvc_unlock_type;
  typedef enum {RD_IDLE, RD_SLOT, RD_LATCH} nvc_rd_type;

  nvc_unlock_type unlock;
  nvc_rd_type rd_state;
  nvc_pkg::nvc_control_type ctrl;
  logic [7:0] addr_low;
  logic [4:0] addr_high;
  logic [7:0] data_low;
  logic [7:0] data_high;
  logic [31:0] lockout_count;
  logic lockout;
  logic aw_held;
  logic w_held;
  logic [13:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_busy;
  logic wr_done;
  logic started;

  // ****************************************
  // decode
  // ****************************************
  function automatic logic mapped(input logic [13:0] a);
    mapped = (a == nvc_pkg::ADDR_DATA_LOW) || (a == nvc_pkg::ADDR_ADDR_LOW) ||
      (a == nvc_pkg::ADDR_ADDR_HIGH) || (a == nvc_pkg::ADDR_CONTROL) ||
      (a == nvc_pkg::ADDR_UNLOCK) || (a == nvc_pkg::ADDR_DATA_HIGH) ||
      (a == nvc_pkg::ADDR_STATUS);
  endfunction

  wire have_aw = aw_held || s_axi_awvalid;
  wire have_w = w_held || s_axi_wvalid;
  wire [13:0] cur_aw = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] cur_w = w_held ? w_data : s_axi_wdata;
  wire [3:0] cur_strb = w_held ? w_strb : s_axi_wstrb;
  wire do_write = have_aw && have_w && !s_axi_bvalid;
  wire lane0 = cur_strb[0];
  wire wr_ok = do_write && mapped(cur_aw) && lane0;
  wire do_read = s_axi_arvalid && s_axi_arready;
  wire hit_ctrl = wr_ok && (cur_aw == nvc_pkg::ADDR_CONTROL);
  wire hit_unlock = wr_ok && (cur_aw == nvc_pkg::ADDR_UNLOCK);
  wire hit_status = wr_ok && (cur_aw == nvc_pkg::ADDR_STATUS);
  wire hit_alow = wr_ok && (cur_aw == nvc_pkg::ADDR_ADDR_LOW);
  wire hit_ahigh = wr_ok && (cur_aw == nvc_pkg::ADDR_ADDR_HIGH);
  wire hit_dlow = wr_ok && (cur_aw == nvc_pkg::ADDR_DATA_LOW);
  wire hit_dhigh = wr_ok && (cur_aw == nvc_pkg::ADDR_DATA_HIGH);
  wire [7:0] wbyte = cur_w[7:0];
  wire set_store = hit_ctrl && wbyte[nvc_pkg::BIT_STORE];
  wire set_read = hit_ctrl && wbyte[nvc_pkg::BIT_READ] && !wr_busy;
  wire space_now = ctrl.space_select;
  wire store_legal = set_store && (unlock == UNLOCK_ARMED) &&
    ctrl.write_permit && !lockout && !space_now && !wr_busy;
  wire any_access = do_write || do_read;
  wire key_first = hit_unlock && (wbyte == nvc_pkg::KEY_FIRST);
  wire key_second = hit_unlock && (wbyte == nvc_pkg::KEY_SECOND);
  wire [7:0] ctrl_byte = {ctrl.space_select, 1'b0, ctrl.time_limit,
    ctrl.write_fault, ctrl.write_permit, ctrl.store_trigger,
    ctrl.read_trigger};
  wire [7:0] status_byte = {5'h0, lockout, wr_busy, write_done_flag};

  logic [7:0] next_rbyte;
  always_comb begin
    case (s_axi_araddr)
      nvc_pkg::ADDR_DATA_LOW: next_rbyte = data_low;
      nvc_pkg::ADDR_ADDR_LOW: next_rbyte = addr_low;
      nvc_pkg::ADDR_ADDR_HIGH: next_rbyte = {3'h0, addr_high};
      nvc_pkg::ADDR_CONTROL: next_rbyte = ctrl_byte;
      nvc_pkg::ADDR_DATA_HIGH: next_rbyte = data_high;
      nvc_pkg::ADDR_STATUS: next_rbyte = status_byte;
      default: next_rbyte = 8'h00;
    endcase
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 14'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) &&
        !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) &&
        !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? nvc_pkg::NVC_AXI_OKAY :
          nvc_pkg::NVC_AXI_SLVERR;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write effects fire once, when both halves are held
  assign started = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h0, next_rbyte};
        s_axi_rresp <= mapped(s_axi_araddr) ? nvc_pkg::NVC_AXI_OKAY :
          nvc_pkg::NVC_AXI_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // unlock tracker and lockout
  // ****************************************
  wire effect = started && any_access;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unlock <= UNLOCK_IDLE;
    end else if (effect || do_read) begin
      case (unlock)
        UNLOCK_IDLE: unlock <= key_first && started ? UNLOCK_FIRST :
          UNLOCK_IDLE;
        UNLOCK_FIRST: unlock <= key_second && started ? UNLOCK_ARMED :
          UNLOCK_IDLE;
        UNLOCK_ARMED: unlock <= UNLOCK_IDLE;
        default: unlock <= UNLOCK_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lockout_count <= 32'h0;
      lockout <= 1'b1;
    end else if (lockout) begin
      lockout_count <= lockout_count + 32'h1;
      lockout <= (lockout_count + 32'h1 < 32'(POWERUP_CYCLES));
    end
  end

  // ****************************************
  // control register
  // ****************************************
  wire commit = started;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl.space_select <= 1'b0;
      ctrl.time_limit <= 2'b00;
      ctrl.write_permit <= 1'b0;
      ctrl.store_trigger <= 1'b0;
      ctrl.write_fault <= 1'b0;
      ctrl.read_trigger <= 1'b0;
    end else begin
      ctrl.read_trigger <= (rd_state == RD_IDLE) ? (commit && set_read) :
        !((rd_state == RD_LATCH) && !mem_read.req);
      if (commit && hit_ctrl) begin
        ctrl.space_select <= wbyte[nvc_pkg::BIT_SPACE];
        ctrl.time_limit <= wbyte[nvc_pkg::BIT_TIME_HI:nvc_pkg::BIT_TIME_LO];
        ctrl.write_permit <= wbyte[nvc_pkg::BIT_PERMIT];
      end
      if (commit && store_legal) begin
        ctrl.store_trigger <= 1'b1;
      end else if (wr_done) begin
        ctrl.store_trigger <= 1'b0;
      end
      // fault flag outlives the reset cause so software sees the abort
      if (fault_reset_cause && wr_busy) begin
        ctrl.write_fault <= 1'b1;
      end else if (commit && hit_ctrl && !wbyte[nvc_pkg::BIT_FAULT]) begin
        ctrl.write_fault <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      write_done_flag <= 1'b0;
    end else if (wr_done) begin
      write_done_flag <= 1'b1;
    end else if (commit && hit_status && wbyte[nvc_pkg::BIT_DONE]) begin
      write_done_flag <= 1'b0;
    end
  end

  // ****************************************
  // address and data registers, read sequence
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_low <= 8'h00;
      addr_high <= 5'h00;
      rd_state <= RD_IDLE;
      mem_read <= '0;
    end else begin
      if (commit && hit_alow) addr_low <= wbyte;
      if (commit && hit_ahigh) addr_high <= wbyte[4:0];
      mem_read.req <= 1'b0;
      case (rd_state)
        RD_IDLE: begin
          if (commit && set_read) begin
            rd_state <= RD_SLOT;
          end
        end
        RD_SLOT: begin
          mem_read.req <= 1'b1;
          mem_read.space <= ctrl.space_select;
          mem_read.addr <= ctrl.space_select ? {addr_high, addr_low} :
            {6'h00, addr_low[6:0] & nvc_pkg::DATA_ADDR_MASK};
          rd_state <= RD_LATCH;
        end
        RD_LATCH: begin
          if (!mem_read.req) begin
            rd_state <= RD_IDLE;
          end
        end
        default: rd_state <= RD_IDLE;
      endcase
    end
  end

  // the array answers on the edge after req, so the word is taken one later
  wire latch_now = (rd_state == RD_LATCH) && !mem_read.req;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_low <= 8'h00;
      data_high <= 8'h00;
    end else if (latch_now) begin
      data_low <= mem_rdata[7:0];
      if (mem_read.space) data_high <= mem_rdata[15:8];
    end else begin
      if (commit && hit_dlow) data_low <= wbyte;
      if (commit && hit_dhigh) data_high <= wbyte;
    end
  end

  // ****************************************
  // store cycle
  // ****************************************
  wire start_store = commit && store_legal;
  wire rejected = commit && set_store && !store_legal;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_write <= '0;
      core_stall <= 1'b0;
    end else begin
      mem_write.req <= start_store;
      if (start_store) begin
        mem_write.addr <= addr_low[6:0];
        mem_write.data <= data_low;
      end
      core_stall <= start_store || mem_write.req ||
        (wr_busy && !wr_done);
    end
  end

  nvc_write_timer #(
    .LIMIT_1(LIMIT_1),
    .LIMIT_2(LIMIT_2),
    .LIMIT_3(LIMIT_3),
    .LIMIT_4(LIMIT_4)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(mem_write.req),
    .time_sel(ctrl.time_limit),
    .verify_ok(mem_verify_ok),
    .busy(wr_busy),
    .done(wr_done)
  );

  // a rejected trigger never sets the bit, so it reads back as zero
  wire unused_ok = rejected | (|cur_w[31:8]) | (|s_axi_awaddr[1:0]);

endmodule

// file: sim/nvc_mem_model.sv
/*
  nvc_mem_model: behavioural data store and code memory behind nvc_top.
  assumes one-cycle read and store requests from the controller.
*/
module nvc_mem_model #(
  parameter int VERIFY_CYCLES = 5
) (
  // clock
  input wire logic aclk,
  // requests
  input wire nvc_pkg::nvc_read_req_type mem_read,
  input wire nvc_pkg::nvc_write_req_type mem_write,
  input wire logic verify_en,
  // answers
  output logic [15:0] mem_rdata,
  output logic mem_verify_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cells [128];
  int left = 0;
  // ****************************************
  // array
  // ****************************************
  initial begin
    for (int i = 0; i < 128; i++) cells[i] = 8'(i) ^ 8'h5A;
    mem_rdata = 16'h0000;
    mem_verify_ok = 1'b0;
  end
  always @(posedge aclk) begin
    mem_verify_ok <= 1'b0;
    if (mem_read.req) begin
      if (mem_read.space)
        mem_rdata <= {mem_read.addr[7:0], 3'h0, mem_read.addr[12:8]} ^ 16'h3C3C;
      else
        mem_rdata <= {8'h00, cells[mem_read.addr[6:0]]};
    end else begin
      // data valid one cycle only: flipping exposes a late sample
      mem_rdata <= ~mem_rdata;
    end
    if (mem_write.req) begin
      cells[mem_write.addr] <= mem_write.data;
      left <= VERIFY_CYCLES;
    end else if (left > 0) begin
      left <= left - 1;
      // with verify off only the time limit can end the store
      mem_verify_ok <= verify_en && left == 1;
    end
  end
endmodule

// file: sim/nvc_top_props.sv
/*
  nvc_top_props: concurrent checks on the ports of nvc_top.
  assumes one clock domain and shortened limits below 80 cycles.
*/
module nvc_top_props #(
  parameter int POWERUP_CYCLES = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic s_axi_wvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // arrays and core
  input wire nvc_pkg::nvc_read_req_type mem_read,
  input wire nvc_pkg::nvc_write_req_type mem_write,
  input wire logic mem_verify_ok,
  input wire logic core_stall,
  input wire logic write_done_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  int up_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_cnt <= 0;
    end else if (up_cnt < POWERUP_CYCLES) begin
      up_cnt <= up_cnt + 1;
    end
  end
  // ****************************************
  // properties
  // ****************************************
  sequence s_no_bus_write;
    !s_axi_wvalid [*3];
  endsequence
  sequence s_store_ends;
    ##[1:80] !core_stall;
  endsequence
  property p_stall_on_store;
    mem_write.req |-> ##[0:1] core_stall;
  endproperty
  a_stall_on_store: assert property (p_stall_on_store)
    else $error("store started without core stall");
  property p_store_bounded;
    $rose(core_stall) |-> s_store_ends;
  endproperty
  a_store_bounded: assert property (p_store_bounded)
    else $error("store outlived the longest time limit");
  property p_verify_ends;
    mem_verify_ok && core_stall |-> ##[1:2] !core_stall;
  endproperty
  a_verify_ends: assert property (p_verify_ends)
    else $error("store kept running after verify");
  property p_done_on_verify;
    mem_verify_ok && core_stall |-> ##[1:3] write_done_flag;
  endproperty
  a_done_on_verify: assert property (p_done_on_verify)
    else $error("done flag missing after store");
  property p_done_sticky;
    (s_no_bus_write ##0 write_done_flag) |=> write_done_flag;
  endproperty
  a_done_sticky: assert property (p_done_sticky)
    else $error("done flag dropped without software");
  property p_lockout;
    up_cnt < POWERUP_CYCLES |-> !mem_write.req;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("store during power-up lockout");
  property p_read_pulse;
    mem_read.req |=> !mem_read.req;
  endproperty
  a_read_pulse: assert property (p_read_pulse)
    else $error("read trigger not cleared");
  property p_no_read_busy;
    core_stall |-> !mem_read.req;
  endproperty
  a_no_read_busy: assert property (p_no_read_busy)
    else $error("read issued while core stalled");
  property p_single_store;
    core_stall && $past(core_stall) |-> !mem_write.req;
  endproperty
  a_single_store: assert property (p_single_store)
    else $error("second store during a running store");
  property p_read_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer late");
endmodule

bind nvc_top nvc_top_props #(.POWERUP_CYCLES(POWERUP_CYCLES)) i_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .mem_read(mem_read), .mem_write(mem_write),
  .mem_verify_ok(mem_verify_ok), .core_stall(core_stall),
  .write_done_flag(write_done_flag)
);

// file: sim/tb.sv
/*
  tb: self-checking bench for nvc_top with the array model behind it.
  assumes shortened lockout and time limits handed down as parameters.
*/
`define CHK(nm, ex, got) begin \
  comparisons++; \
  if ((got) !== (ex)) begin \
    num_errors++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PWR = 20;
  localparam int LIM [4] = '{8, 16, 32, 64};
  localparam logic [7:0] PERMIT = 8'h04;
  localparam logic [7:0] STORE = 8'h02;
  localparam logic [7:0] SPACE = 8'h80;
  logic aclk, aresetn, fault_reset_cause, verify_en;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, mem_verify_ok, core_stall;
  logic write_done_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] mem_rdata;
  nvc_pkg::nvc_read_req_type mem_read;
  nvc_pkg::nvc_write_req_type mem_write;
  int num_errors = 0, comparisons = 0, writes = 0, stall_n = 0;

  nvc_top #(.POWERUP_CYCLES(PWR), .LIMIT_1(LIM[0]), .LIMIT_2(LIM[1]),
    .LIMIT_3(LIM[2]), .LIMIT_4(LIM[3])) i_dut (.aclk, .aresetn,
    .fault_reset_cause, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .mem_read, .mem_rdata, .mem_write, .mem_verify_ok,
    .core_stall, .write_done_flag);
  nvc_mem_model i_mem (.aclk, .mem_read, .mem_write, .verify_en,
    .mem_rdata, .mem_verify_ok);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (mem_write.req === 1'b1) writes++;
    if (core_stall === 1'b1) stall_n++;
  end
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic axi_wr(input logic [13:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask
  task automatic axi_rd(input logic [13:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask
  task automatic store_seq(input logic [7:0] k1, k2, ctl);
    axi_wr(nvc_pkg::ADDR_UNLOCK, k1);
    axi_wr(nvc_pkg::ADDR_UNLOCK, k2);
    axi_wr(nvc_pkg::ADDR_CONTROL, ctl);
  endtask
  task automatic wait_idle;
    repeat (2) @(posedge aclk);
    while (core_stall !== 1'b0) @(posedge aclk);
  endtask
  task automatic rd_byte(input logic [7:0] a, input logic [7:0] ex);
    axi_wr(nvc_pkg::ADDR_ADDR_LOW, a);
    axi_wr(nvc_pkg::ADDR_CONTROL, 8'h01);
    repeat (2) @(posedge aclk);
    axi_rd(nvc_pkg::ADDR_DATA_LOW);
    `CHK("data byte", ex, rd[7:0]);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_lockout;
    axi_wr(nvc_pkg::ADDR_CONTROL, PERMIT);
    store_seq(8'h55, 8'hAA, PERMIT | STORE);
    repeat (PWR) @(posedge aclk);
    `CHK("stores in lockout", 0, writes);
  endtask
  task automatic t_store;
    axi_wr(nvc_pkg::ADDR_ADDR_LOW, 8'h7F);
    axi_wr(nvc_pkg::ADDR_DATA_LOW, 8'hC3);
    axi_wr(nvc_pkg::ADDR_CONTROL, PERMIT | 8'h30);
    stall_n = 0;
    store_seq(8'h55, 8'hAA, PERMIT | 8'h30 | STORE);
    axi_wr(nvc_pkg::ADDR_CONTROL, 8'h30);
    wait_idle;
    `CHK("stored byte", 8'hC3, i_mem.cells[127]);
    `CHK("stores", 1, writes);
    `CHK("short store", 1'b1, stall_n > 0 && stall_n <= 8);
    `CHK("done flag", 1'b1, write_done_flag);
    axi_rd(nvc_pkg::ADDR_CONTROL);
    `CHK("triggers", 2'b00, rd[1:0]);
    axi_wr(nvc_pkg::ADDR_STATUS, 8'h01);
    `CHK("done cleared", 1'b0, write_done_flag);
    rd_byte(8'h7F, 8'hC3);
    rd_byte(8'h00, 8'h5A);
  endtask
  task automatic t_code;
    axi_wr(nvc_pkg::ADDR_ADDR_HIGH, 8'h1F);
    axi_wr(nvc_pkg::ADDR_ADDR_LOW, 8'hFE);
    axi_wr(nvc_pkg::ADDR_CONTROL, SPACE | 8'h01);
    repeat (2) @(posedge aclk);
    axi_rd(nvc_pkg::ADDR_DATA_LOW);
    `CHK("code low", 8'h1F ^ 8'h3C, rd[7:0]);
    axi_rd(nvc_pkg::ADDR_DATA_HIGH);
    `CHK("code high", 8'hFE ^ 8'h3C, rd[7:0]);
    axi_wr(nvc_pkg::ADDR_CONTROL, SPACE | 8'h30 | PERMIT);
    axi_rd(nvc_pkg::ADDR_CONTROL);
    `CHK("control layout", 8'hB4, rd[7:0]);
    axi_rd(14'h0000);
    `CHK("unmapped resp", 2'b10, resp);
    axi_wr(14'h0000, 8'h00);
    `CHK("unmapped write resp", 2'b10, resp);
  endtask
  task automatic t_refused;
    logic [7:0] pre [4] = '{PERMIT, 8'h00, SPACE | PERMIT, PERMIT};
    logic [7:0] k1 [4] = '{8'hAA, 8'h55, 8'h55, 8'h55};
    logic [7:0] k2 [4] = '{8'h55, 8'hAA, 8'hAA, 8'hAA};
    logic [7:0] ctl [4] = '{PERMIT | STORE, STORE,
      SPACE | PERMIT | STORE, PERMIT | STORE};
    int w0;
    w0 = writes;
    for (int i = 0; i < 4; i++) begin
      axi_wr(nvc_pkg::ADDR_CONTROL, pre[i]);
      axi_wr(nvc_pkg::ADDR_UNLOCK, k1[i]);
      if (i == 3) axi_rd(nvc_pkg::ADDR_STATUS);
      axi_wr(nvc_pkg::ADDR_UNLOCK, k2[i]);
      axi_wr(nvc_pkg::ADDR_CONTROL, ctl[i]);
      repeat (4) @(posedge aclk);
      `CHK("refused store", w0, writes);
      axi_rd(nvc_pkg::ADDR_CONTROL);
      `CHK("store bit", 1'b0, rd[1]);
    end
  endtask
  task automatic t_limits;
    logic [7:0] c;
    verify_en <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      c = PERMIT | 8'(s << 4);
      axi_wr(nvc_pkg::ADDR_CONTROL, c);
      stall_n = 0;
      store_seq(8'h55, 8'hAA, c | STORE);
      wait_idle;
      `CHK("limit", 1'b1, stall_n >= LIM[s] - 1 && stall_n <= LIM[s] + 2);
      axi_rd(nvc_pkg::ADDR_CONTROL);
      `CHK("permit kept", 1'b1, rd[2]);
    end
    store_seq(8'h55, 8'hAA, PERMIT | 8'h30 | STORE);
    fault_reset_cause <= 1'b1;
    @(posedge aclk);
    fault_reset_cause <= 1'b0;
    wait_idle;
    axi_rd(nvc_pkg::ADDR_CONTROL);
    `CHK("fault bit", 1'b1, rd[3]);
    axi_wr(nvc_pkg::ADDR_CONTROL, 8'h00);
    axi_rd(nvc_pkg::ADDR_CONTROL);
    `CHK("fault cleared", 1'b0, rd[3]);
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic complete_run;
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    complete_run;
  end
  initial begin
    {aresetn, fault_reset_cause, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_arvalid, s_axi_bready, s_axi_rready, verify_en} = 4'h7;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_lockout;
    repeat (PWR) @(posedge aclk);
    t_store;
    t_code;
    t_refused;
    t_limits;
    complete_run;
  end
endmodule
